// ===== logic/alert_vout_pkg.sv
// constants for the alert-mask and output-voltage format command registers
package alert_vout_pkg;
    // command codes and selector bytes
    localparam logic [7:0] CMD_ALERT_MASK      = 8'h1b;
    localparam logic [7:0] CMD_VOUT_FORMAT     = 8'h20;
    localparam logic [7:0] SEL_VENDOR_MASK     = 8'h80;
    localparam logic [7:0] SEL_MISC_MASK       = 8'h7f;

    // vendor status alert mask field positions
    localparam int POS_POWER_ON_RESTART = 7;
    localparam int POS_INTERNAL_CHECK   = 6;
    localparam int POS_PIN_RESTART      = 3;
    localparam int POS_BACKCHANNEL      = 2;
    localparam int POS_FREQUENCY_LOCK   = 1;
    localparam logic [7:0] VENDOR_MASK_WRITABLE = 8'hce;

    // misc status alert mask: only the first-alerter bit, fixed at one
    localparam logic [7:0] MISC_MASK_VALUE      = 8'h01;

    // output voltage format byte layout
    localparam int POS_OFFSET_FORMAT    = 7;
    localparam int MODE_MSB             = 6;
    localparam int MODE_LSB             = 5;
    localparam int EXP_MSB              = 4;
    localparam int EXP_LSB              = 0;
    localparam logic [1:0] MODE_LINEAR  = 2'b00;
    localparam logic [7:0] FORMAT_WRITABLE = 8'h9f;

    // supported exponent range in two's complement: -12 .. -4
    localparam logic [4:0] EXP_MIN      = 5'h14;
    localparam logic [4:0] EXP_MAX      = 5'h1c;

    // value answered for a read of an unmapped command
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    typedef enum logic [1:0]
    {
        INIT_WAIT_NVM = 2'b00,
        INIT_READY    = 2'b01
    } init_state_t;
endpackage : alert_vout_pkg

// ===== logic/format_rescaler.sv
// rescales a stored voltage value to a new exponent and absolute/relative form
`timescale 1ns/1ps
module format_rescaler
    import alert_vout_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [4:0]  old_exp,
    input  wire logic [4:0]  new_exp,
    input  wire logic        old_rel,
    input  wire logic        new_rel,
    input  wire logic [15:0] value_in,
    input  wire logic [15:0] reference,
    output logic      [15:0] value_out,
    output logic             done
);
    logic signed [5:0] delta;
    logic        [3:0] shift_left;
    logic        [3:0] shift_right;
    logic       [15:0] scaled;
    logic       [15:0] next_value;

    // a finer new exponent (more negative) needs a left shift of the mantissa
    assign delta       = $signed({old_exp[4], old_exp}) - $signed({new_exp[4], new_exp});
    assign shift_left  = delta[5] ? 4'h0 : delta[3:0];
    assign shift_right = delta[5] ? 4'(-delta) : 4'h0;
    assign scaled      = delta[5] ? (value_in >> shift_right) : (value_in << shift_left);
    // reference is in the new units; relative values are offsets from it
    assign next_value  = (old_rel == new_rel) ? scaled :
                         (new_rel ? 16'(scaled - reference) : 16'(scaled + reference));

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value_out <= 16'h0000;
            done      <= 1'b0;
        end
        else
        begin
            done <= start;
            if (start)
            begin
                value_out <= next_value;
            end
        end
    end
endmodule : format_rescaler

// ===== logic/alert_mask_vout_format_regs.sv
// alert-mask and output-voltage format command registers with alert gating
`timescale 1ns/1ps

module alert_mask_vout_format_regs
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // defaults from nonvolatile memory
    input  wire logic        nvm_valid,
    input  wire logic [7:0]  nvm_vendor_mask,
    input  wire logic [7:0]  nvm_format,
    // decoded command port from the bus protocol engine
    input  wire logic        cmd_write,
    input  wire logic        cmd_read,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [7:0]  cmd_selector,
    input  wire logic [7:0]  cmd_wdata,
    output logic [7:0]       cmd_rdata,
    output logic             cmd_rvalid,
    output logic             cmd_invalid,
    output logic             host_ready,
    // device state
    input  wire logic        conversion_enable,
    input  wire logic [7:0]  vendor_status_byte,
    input  wire logic        first_alerter_flag,
    // alert line, open drain
    output logic             smbalert_out,
    output logic             smbalert_oe,
    // active format for the voltage datapath
    output logic             offset_format_flag,
    output logic [4:0]       format_exponent,
    // stored voltage value conversion
    input  wire logic [15:0] vout_value_in,
    input  wire logic [15:0] vout_reference,
    output logic [15:0]      vout_value_out,
    output logic             vout_rescale_done
);
    import alert_vout_pkg::*;

    logic        rst_meta;
    logic        rst_n;
    init_state_t init_state;
    init_state_t next_init_state;
    logic [7:0]  vendor_mask;
    logic        rel_flag;
    logic [4:0]  exponent;
    logic        old_rel;
    logic [4:0]  old_exp;
    logic        rescale_start;

    // reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // nvm load sequencing
    wire ready       = (init_state == INIT_READY);
    wire nvm_load    = (init_state == INIT_WAIT_NVM) && nvm_valid;

    always_comb
    begin
        next_init_state = init_state;
        case (init_state)
            INIT_WAIT_NVM:
            begin
                if (nvm_valid)
                begin
                    next_init_state = INIT_READY;
                end
            end
            INIT_READY:
            begin
                next_init_state = INIT_READY;
            end
            default:
            begin
                next_init_state = INIT_WAIT_NVM;
            end
        endcase
    end

    // command decode
    wire hit_vendor  = (cmd_code == CMD_ALERT_MASK) && (cmd_selector == SEL_VENDOR_MASK);
    wire hit_misc    = (cmd_code == CMD_ALERT_MASK) && (cmd_selector == SEL_MISC_MASK);
    wire hit_format  = (cmd_code == CMD_VOUT_FORMAT);
    wire hit_any     = hit_vendor || hit_misc || hit_format;

    wire [4:0] wr_exp  = cmd_wdata[EXP_MSB:EXP_LSB];
    wire [1:0] wr_mode = cmd_wdata[MODE_MSB:MODE_LSB];
    // only linear mode with an exponent inside -12..-4 is accepted
    wire exp_ok      = (wr_exp >= EXP_MIN) && (wr_exp <= EXP_MAX);
    wire mode_ok     = (wr_mode == MODE_LINEAR);
    wire format_data_ok = exp_ok && mode_ok;

    wire wr_ok       = cmd_write && ready;
    wire wr_vendor   = wr_ok && hit_vendor;
    // format is read-only while the converter runs
    wire wr_format   = wr_ok && hit_format && !conversion_enable && format_data_ok;
    wire wr_format_changes = wr_format &&
                             ((cmd_wdata[POS_OFFSET_FORMAT] != rel_flag) || (wr_exp != exponent));

    // refused: before nvm load, unmapped code, misc mask write, bad format write, format write while the converter runs
    wire next_invalid = (cmd_write && (!ready || !hit_any || hit_misc ||
                                       (hit_format && (conversion_enable || !format_data_ok))))
                     || (cmd_read && (!ready || !hit_any));

    // read mux
    wire [7:0] format_byte = {rel_flag, MODE_LINEAR, exponent};
    wire [7:0] next_rdata  = !ready     ? READ_UNMAPPED :
                             hit_vendor ? (vendor_mask & VENDOR_MASK_WRITABLE) :
                             hit_misc   ? MISC_MASK_VALUE :
                             hit_format ? format_byte :
                                          READ_UNMAPPED;

    // alert gating: only writable vendor bits can pass, the first-alerter flag has no path
    wire [7:0] unmasked    = vendor_status_byte & ~vendor_mask & VENDOR_MASK_WRITABLE;
    wire       alert_cause = |unmasked;
    wire       unused_flag = first_alerter_flag;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            init_state <= INIT_WAIT_NVM;
        end
        else
        begin
            init_state <= next_init_state;
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vendor_mask <= 8'h00;
            rel_flag    <= 1'b0;
            exponent    <= EXP_MAX;
        end
        else if (nvm_load)
        begin
            vendor_mask <= nvm_vendor_mask & VENDOR_MASK_WRITABLE;
            rel_flag    <= nvm_format[POS_OFFSET_FORMAT];
            exponent    <= nvm_format[EXP_MSB:EXP_LSB];
        end
        else
        begin
            if (wr_vendor)
            begin
                vendor_mask <= cmd_wdata & VENDOR_MASK_WRITABLE;
            end
            if (wr_format)
            begin
                rel_flag <= cmd_wdata[POS_OFFSET_FORMAT];
                exponent <= wr_exp;
            end
        end
    end

    // answers and alert output
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_rdata     <= 8'h00;
            cmd_rvalid    <= 1'b0;
            cmd_invalid   <= 1'b0;
            smbalert_oe   <= 1'b0;
            old_rel       <= 1'b0;
            old_exp       <= EXP_MAX;
            rescale_start <= 1'b0;
        end
        else
        begin
            cmd_rvalid    <= cmd_read;
            cmd_invalid   <= next_invalid;
            smbalert_oe   <= ready && alert_cause;
            rescale_start <= wr_format_changes;
            if (cmd_read)
            begin
                cmd_rdata <= next_rdata;
            end
            if (wr_format_changes)
            begin
                old_rel <= rel_flag;
                old_exp <= exponent;
            end
        end
    end

    // the line is only ever pulled low
    assign smbalert_out       = 1'b0;
    assign host_ready         = ready;
    assign offset_format_flag = rel_flag;
    assign format_exponent    = exponent;

    // conversion runs one cycle after the new format is stored
    format_rescaler u_rescaler
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .start     (rescale_start),
        .old_exp   (old_exp),
        .new_exp   (exponent),
        .old_rel   (old_rel),
        .new_rel   (rel_flag),
        .value_in  (vout_value_in),
        .reference (vout_reference),
        .value_out (vout_value_out),
        .done      (vout_rescale_done)
    );
endmodule : alert_mask_vout_format_regs

// ===== dv/alert_regs_props.sv
// concurrent checks on the command port, format state and alert line
`timescale 1ns/1ps
module alert_regs_props
    import alert_vout_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       host_ready,
    input wire logic       cmd_write,
    input wire logic       cmd_read,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_selector,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rdata,
    input wire logic       cmd_rvalid,
    input wire logic       cmd_invalid,
    input wire logic       conversion_enable,
    input wire logic [7:0] vendor_status_byte,
    input wire logic       smbalert_oe,
    input wire logic       offset_format_flag,
    input wire logic [4:0] format_exponent,
    input wire logic       vout_rescale_done
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    wire logic fmt_wr  = host_ready && cmd_write && cmd_code == CMD_VOUT_FORMAT;
    wire logic exp_ok  = cmd_wdata[4:0] >= EXP_MIN && cmd_wdata[4:0] <= EXP_MAX;
    wire logic fmt_ok  = fmt_wr && !conversion_enable && cmd_wdata[6:5] == MODE_LINEAR && exp_ok;
    wire logic fmt_chg = fmt_ok &&
        ({cmd_wdata[7], cmd_wdata[4:0]} != {offset_format_flag, format_exponent});
    wire logic rd_1b   = host_ready && cmd_read && cmd_code == CMD_ALERT_MASK;
    a_misc_mask_one: assert property (rd_1b && cmd_selector == SEL_MISC_MASK |=>
        cmd_rvalid && cmd_rdata == MISC_MASK_VALUE) else $error("misc mask read wrong");
    a_vendor_mask_read: assert property (rd_1b && cmd_selector == SEL_VENDOR_MASK
        |=> cmd_rvalid && (cmd_rdata & ~VENDOR_MASK_WRITABLE) == 8'h00)
        else $error("vendor read wrong");
    a_format_read: assert property (host_ready && cmd_read && cmd_code == CMD_VOUT_FORMAT
        |=> cmd_rdata == {$past(offset_format_flag), MODE_LINEAR, $past(format_exponent)})
        else $error("format read wrong");
    a_format_accept: assert property (fmt_ok |=>
        {offset_format_flag, 2'b00, format_exponent} == $past(cmd_wdata))
        else $error("format not taken");
    a_format_locked: assert property (fmt_wr && conversion_enable |=> cmd_invalid &&
        $stable(format_exponent) && $stable(offset_format_flag))
        else $error("locked format changed");
    a_exponent_range: assert property (fmt_wr && !exp_ok |=> cmd_invalid &&
        $stable(format_exponent)) else $error("bad exponent taken");
    a_rescale_once: assert property (fmt_chg |=> !vout_rescale_done ##1 vout_rescale_done)
        else $error("rescale missing");
    a_alert_gated: assert property ((vendor_status_byte & VENDOR_MASK_WRITABLE) == 8'h00
        |=> !smbalert_oe) else $error("alert without cause");
    a_early_refuse: assert property (!host_ready && (cmd_read || cmd_write) |=>
        cmd_invalid && !smbalert_oe) else $error("early request taken");
    c_fmt_change: cover property (fmt_chg);
    c_alert: cover property ($rose(smbalert_oe));
    c_locked: cover property (fmt_wr && conversion_enable);
endmodule : alert_regs_props

// ===== dv/pmbus_host_model.sv
// host side of the decoded command port, one byte per call
`timescale 1ns/1ps
module pmbus_host_model
(
    input  wire logic       clk_sys,
    output logic            cmd_write,
    output logic            cmd_read,
    output logic      [7:0] cmd_code,
    output logic      [7:0] cmd_selector,
    output logic      [7:0] cmd_wdata,
    input  wire logic [7:0] cmd_rdata,
    input  wire logic       cmd_rvalid,
    input  wire logic       cmd_invalid
);
    initial
    begin
        {cmd_write, cmd_read, cmd_code, cmd_selector, cmd_wdata} = '0;
    end
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] sel,
                        input logic [7:0] data, output logic [7:0] rdata, output logic ok);
        @(posedge clk_sys);
        #1;
        cmd_write    = wr;
        cmd_read     = !wr;
        cmd_code     = code;
        cmd_selector = sel;
        cmd_wdata    = data;
        @(posedge clk_sys);
        #1;
        ok    = !cmd_invalid && (wr || cmd_rvalid);
        rdata = cmd_rdata;
        {cmd_write, cmd_read} = 2'b00;
        // released fields flip so a stale value is never mistaken for a live one
        {cmd_code, cmd_selector, cmd_wdata} = ~{code, sel, data};
    endtask : xfer
endmodule : pmbus_host_model

// ===== dv/alert_mask_vout_format_regs_tb_top.sv
// self-checking bench for the alert mask and output voltage format registers
`timescale 1ns/1ps
module alert_mask_vout_format_regs_tb_top;
    import alert_vout_pkg::*;
    logic        clk_sys = 1'b0, resetn = 1'b0, nvm_valid = 1'b0;
    logic        conversion_enable = 1'b0, first_alerter_flag = 1'b0;
    logic [7:0]  vendor_status_byte = 8'h00;
    logic [7:0]  nvm_vendor_mask = 8'hff, nvm_format = 8'h9c;
    logic [15:0] vout_value_in = 16'h0000, vout_reference = 16'h0000;
    logic        cmd_write, cmd_read, cmd_rvalid, cmd_invalid, host_ready, ok;
    logic        smbalert_out, smbalert_oe, offset_format_flag, vout_rescale_done;
    logic [7:0]  cmd_code, cmd_selector, cmd_wdata, cmd_rdata, got, m;
    logic [4:0]  format_exponent;
    logic [15:0] vout_value_out;
    logic [7:0]  masks [3] = '{8'h00, 8'hff, 8'h4a};
    logic [7:0]  bad [5] = '{8'h13, 8'h1d, 8'h3c, 8'h5c, 8'h7c};
    int          errors = 0, n_tests = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    alert_mask_vout_format_regs i_dut (.clk_sys, .resetn, .nvm_valid, .nvm_vendor_mask,
        .nvm_format, .cmd_write, .cmd_read, .cmd_code, .cmd_selector, .cmd_wdata,
        .cmd_rdata, .cmd_rvalid, .cmd_invalid, .host_ready, .conversion_enable,
        .vendor_status_byte, .first_alerter_flag, .smbalert_out, .smbalert_oe,
        .offset_format_flag, .format_exponent, .vout_value_in, .vout_reference,
        .vout_value_out, .vout_rescale_done);
    pmbus_host_model i_host (.clk_sys, .cmd_write, .cmd_read, .cmd_code, .cmd_selector,
        .cmd_wdata, .cmd_rdata, .cmd_rvalid, .cmd_invalid);
    task automatic test_done();
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic check(input logic [7:0] act, input logic [7:0] exp);
        n_tests++;
        if (act !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, act, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] code, sel, input logic eok, input logic [7:0] exp);
        i_host.xfer(1'b0, code, sel, 8'h00, got, ok);
        check({7'h00, ok}, {7'h00, eok});
        check(got, exp);
    endtask : rd_chk
    task automatic wr_chk(input logic [7:0] code, sel, data, input logic eok);
        i_host.xfer(1'b1, code, sel, data, got, ok);
        check({7'h00, ok}, {7'h00, eok});
    endtask : wr_chk
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            test_done();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk(CMD_VOUT_FORMAT, 8'h00, 1'b0, READ_UNMAPPED);
        check({7'h00, host_ready}, 8'h00);
        nvm_valid = 1'b1;
        for (int i = 0; i < 20 && host_ready !== 1'b1; i++) @(posedge clk_sys);
        #1 check({7'h00, host_ready}, 8'h01);
        rd_chk(CMD_ALERT_MASK, SEL_VENDOR_MASK, 1'b1, 8'hce);
        rd_chk(CMD_VOUT_FORMAT, 8'h00, 1'b1, 8'h9c);
        rd_chk(CMD_ALERT_MASK, SEL_MISC_MASK, 1'b1, 8'h01);
        wr_chk(CMD_ALERT_MASK, SEL_MISC_MASK, 8'h00, 1'b0);
        rd_chk(CMD_ALERT_MASK, SEL_MISC_MASK, 1'b1, 8'h01);
        rd_chk(8'h21, 8'h00, 1'b0, READ_UNMAPPED);
        first_alerter_flag = 1'b1;
        foreach (masks[k])
        begin
            m = masks[k];
            wr_chk(CMD_ALERT_MASK, SEL_VENDOR_MASK, m, 1'b1);
            rd_chk(CMD_ALERT_MASK, SEL_VENDOR_MASK, 1'b1, m & 8'hce);
            for (int i = 0; i < 8; i++)
            begin
                vendor_status_byte = 8'h01 << i;
                repeat (2) @(posedge clk_sys);
                #1 check({7'h00, smbalert_oe}, (8'hce & ~m) >> i & 8'h01);
            end
            vendor_status_byte = 8'h00;
            repeat (2) @(posedge clk_sys);
            #1 check({7'h00, smbalert_oe}, 8'h00);
        end
        vout_value_in = 16'h0003;
        wr_chk(CMD_VOUT_FORMAT, 8'h00, 8'h95, 1'b1);
        check({offset_format_flag, 2'b00, format_exponent}, 8'h95);
        @(posedge clk_sys);
        #1 check({7'h00, vout_rescale_done}, 8'h01);
        check(vout_value_out[15:8], 8'h01);
        check(vout_value_out[7:0], 8'h80);
        rd_chk(CMD_VOUT_FORMAT, 8'h00, 1'b1, 8'h95);
        vout_value_in = 16'h0180;
        vout_reference = 16'h0010;
        wr_chk(CMD_VOUT_FORMAT, 8'h00, 8'h1c, 1'b1);
        @(posedge clk_sys);
        #1 check(vout_value_out[7:0], 8'h13);
        check(vout_value_out[15:8], 8'h00);
        foreach (bad[k])
        begin
            wr_chk(CMD_VOUT_FORMAT, 8'h00, bad[k], 1'b0);
            rd_chk(CMD_VOUT_FORMAT, 8'h00, 1'b1, 8'h1c);
        end
        wr_chk(CMD_VOUT_FORMAT, 8'h00, 8'h94, 1'b1);
        conversion_enable = 1'b1;
        wr_chk(CMD_VOUT_FORMAT, 8'h00, 8'h1c, 1'b0);
        rd_chk(CMD_VOUT_FORMAT, 8'h00, 1'b1, 8'h94);
        conversion_enable = 1'b0;
        check({7'h00, smbalert_out}, 8'h00);
        // second power-on with other defaults, unwritable bits set on purpose
        resetn = 1'b0;
        nvm_valid = 1'b0;
        nvm_vendor_mask = 8'h7b;
        nvm_format = 8'h74;
        repeat (3) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 check({7'h00, host_ready}, 8'h00);
        nvm_valid = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 check({7'h00, host_ready}, 8'h01);
        rd_chk(CMD_ALERT_MASK, SEL_VENDOR_MASK, 1'b1, 8'h4a);
        rd_chk(CMD_VOUT_FORMAT, 8'h00, 1'b1, 8'h14);
        test_done();
    end
endmodule : alert_mask_vout_format_regs_tb_top
bind alert_mask_vout_format_regs alert_regs_props i_props (.clk_sys, .resetn, .host_ready,
    .cmd_write, .cmd_read, .cmd_code, .cmd_selector, .cmd_wdata, .cmd_rdata, .cmd_rvalid,
    .cmd_invalid, .conversion_enable, .vendor_status_byte, .smbalert_oe,
    .offset_format_flag, .format_exponent, .vout_rescale_done);
